// [operator_panel.sv]
// Operator push-button model for the self-test block
`timescale 1ns/1ps
`default_nettype none
module operator_panel (
    input  wire logic        aclk,
    input  wire logic        press,
    input  wire logic [31:0] hold_cycles,
    output logic             test_button
);
    logic [31:0] left_reg = 32'h0;
    always_ff @(posedge aclk) begin
        if (press) begin
            left_reg <= hold_cycles;
        end else if (left_reg != 32'h0) begin
            left_reg <= left_reg - 32'h1;
        end
    end
    // Clean release edge; no bounce is modelled and the synchroniser does not debounce
    assign test_button = (left_reg != 32'h0);
endmodule : operator_panel
`default_nettype wire

// [self_test_consts.svh]
// Constants for the timed system self-test block
`ifndef SELF_TEST_CONSTS_SVH
`define SELF_TEST_CONSTS_SVH
`define CLK_FREQ_HZ      250000000
`define TICK_MS          1
`define PHASE1_END_MS    2000
`define PHASE2_END_MS    5000
`define FLASH_HALF_MS    500
`define FLICKER_HALF_MS  100
`define OFS_CTRL         12'h000
`define OFS_STATUS       12'h004
`define OFS_IRQ_STATUS   12'h008
`define OFS_IRQ_CLEAR    12'h00c
`define OFS_IRQ_ENABLE   12'h010
`define CTRL_START       0
`define CTRL_TRIP        1
`define CTRL_BTN_ROUTED  2
`define CTRL_LOCAL       3
`define CTRL_SINGLE      4
`define EV_HW_FAULT      0
`define EV_DONE          1
`endif

// [self_test_pkg.sv]
// Types for the timed system self-test block
package self_test_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_LAMP, ST_EVAL, ST_RELAY} phase_t;
    typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_RED, LED_ORANGE} led_t;
endpackage : self_test_pkg

// [timed_system_self_test.sv]
// Timed system self-test sequencer with AXI4-Lite registers
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "self_test_consts.svh"
module timed_system_self_test #(
    parameter int TICK_CYCLES = (`CLK_FREQ_HZ / 1000) * `TICK_MS
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        test_button,
    input  wire logic        hw_test_fail,
    input  wire logic [2:0]  main_current,
    input  wire logic        contactor_request,
    output logic             contactor_out,
    output logic             lamp_control,
    output logic             indicators_all_on,
    output logic             general_fault_indicator,
    output logic [1:0]       device_led,
    output logic             hardware_fault_event,
    output logic             irq
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {main_current, hw_test_fail, test_button};
            sync2_reg <= sync1_reg;
        end
    end
    logic       btn;
    logic       hw_fail;
    logic [2:0] cur;
    assign btn     = sync2_reg[0];
    assign hw_fail = sync2_reg[1];
    assign cur     = sync2_reg[4:2];

    // ************************************************************
    // Register bus
    // ************************************************************
    logic [4:0]  ctrl_reg;
    logic [1:0]  irq_status_reg;
    logic [1:0]  irq_enable_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic        start_pulse;
    logic        do_write;
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_bresp   = 2'h0;
    assign do_write      = aw_held_reg && w_held_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 12'h000;
            wdata_reg    <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign start_pulse = do_write && awaddr_reg == `OFS_CTRL && wdata_reg[`CTRL_START];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg       <= 5'h00;
            irq_enable_reg <= 2'h0;
        end else if (do_write) begin
            if (awaddr_reg == `OFS_CTRL) begin
                ctrl_reg <= {wdata_reg[`CTRL_SINGLE], wdata_reg[`CTRL_LOCAL],
                             wdata_reg[`CTRL_BTN_ROUTED], wdata_reg[`CTRL_TRIP], 1'b0};
            end
            if (awaddr_reg == `OFS_IRQ_ENABLE) begin
                irq_enable_reg <= wdata_reg[1:0];
            end
        end
    end

    // ************************************************************
    // Tick and hold timer
    // ************************************************************
    localparam int TW = $clog2(TICK_CYCLES + 1);
    logic [TW-1:0] tick_cnt_reg;
    logic          tick;
    logic [15:0]   ms_reg;
    logic          fb_run_reg;
    self_test_pkg::phase_t phase_reg;
    assign tick = tick_cnt_reg == TW'(TICK_CYCLES - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn || phase_reg == self_test_pkg::ST_IDLE) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TW'(1);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || phase_reg == self_test_pkg::ST_IDLE) begin
            ms_reg <= 16'h0000;
        end else if (tick && ms_reg != 16'hffff) begin
            ms_reg <= ms_reg + 16'h0001;
        end
    end

    // ************************************************************
    // Phase sequencer
    // ************************************************************
    logic active;
    // Held by button or fieldbus run
    assign active = btn || fb_run_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_reg  <= self_test_pkg::ST_IDLE;
            fb_run_reg <= 1'b0;
        end else begin
            if (start_pulse) begin
                fb_run_reg <= 1'b1;
            end else if (phase_reg == self_test_pkg::ST_RELAY && !btn) begin
                fb_run_reg <= 1'b0;
            end
            case (phase_reg)
                self_test_pkg::ST_IDLE: begin
                    if (btn || start_pulse) begin
                        phase_reg <= self_test_pkg::ST_LAMP;
                    end
                end
                self_test_pkg::ST_LAMP: begin
                    if (!active) begin
                        phase_reg <= self_test_pkg::ST_IDLE;
                    end else if (ms_reg >= 16'(`PHASE1_END_MS)) begin
                        phase_reg <= self_test_pkg::ST_EVAL;
                    end
                end
                self_test_pkg::ST_EVAL: begin
                    if (!active) begin
                        phase_reg <= self_test_pkg::ST_IDLE;
                    end else if (ms_reg >= 16'(`PHASE2_END_MS)) begin
                        phase_reg <= self_test_pkg::ST_RELAY;
                    end
                end
                self_test_pkg::ST_RELAY: begin
                    if (!active) begin
                        phase_reg <= self_test_pkg::ST_IDLE;
                    end
                end
                default: phase_reg <= self_test_pkg::ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Indicator outputs
    // ************************************************************
    logic [9:0] blink_reg;
    logic       flash_reg;
    logic       flick_reg;
    logic       cur_ok;
    logic       no_cur;
    logic       in_eval;
    logic       in_late;
    logic       trip_allowed;
    assign in_eval = phase_reg == self_test_pkg::ST_EVAL;
    assign in_late = in_eval || phase_reg == self_test_pkg::ST_RELAY;
    assign cur_ok  = ctrl_reg[`CTRL_SINGLE] ? |cur : &cur;
    assign no_cur  = cur == 3'h0;
    // Shutdown only when routed and local
    assign trip_allowed = ctrl_reg[`CTRL_BTN_ROUTED] && ctrl_reg[`CTRL_LOCAL];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_reg <= 10'h000;
            flash_reg <= 1'b0;
            flick_reg <= 1'b0;
        end else if (tick) begin
            blink_reg <= (blink_reg == 10'(`FLASH_HALF_MS - 1)) ? 10'h000 : blink_reg + 10'h001;
            if (blink_reg == 10'(`FLASH_HALF_MS - 1)) begin
                flash_reg <= !flash_reg;
            end
            if (blink_reg % 10'(`FLICKER_HALF_MS) == 10'(`FLICKER_HALF_MS - 1)) begin
                flick_reg <= !flick_reg;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lamp_control            <= 1'b0;
            indicators_all_on       <= 1'b0;
            general_fault_indicator <= 1'b0;
            device_led              <= self_test_pkg::LED_OFF;
            contactor_out           <= 1'b0;
        end else begin
            lamp_control      <= phase_reg == self_test_pkg::ST_LAMP;
            indicators_all_on <= phase_reg == self_test_pkg::ST_LAMP;
            if (phase_reg == self_test_pkg::ST_LAMP) begin
                general_fault_indicator <= 1'b1;
            end else if (in_eval && !hw_fail) begin
                general_fault_indicator <= no_cur ? flash_reg : (cur_ok ? flick_reg : 1'b0);
            end else begin
                general_fault_indicator <= 1'b0;
            end
            // Fault shown only after two seconds
            case (phase_reg)
                self_test_pkg::ST_LAMP:  device_led <= self_test_pkg::LED_ORANGE;
                self_test_pkg::ST_EVAL,
                self_test_pkg::ST_RELAY: device_led <= hw_fail ? self_test_pkg::LED_RED
                                                               : self_test_pkg::LED_GREEN;
                default:                 device_led <= self_test_pkg::LED_GREEN;
            endcase
            if (trip_allowed && ((in_late && hw_fail) ||
                (phase_reg == self_test_pkg::ST_RELAY && ctrl_reg[`CTRL_TRIP]))) begin
                contactor_out <= 1'b0;
            end else begin
                contactor_out <= contactor_request;
            end
        end
    end

    // ************************************************************
    // Events and interrupt
    // ************************************************************
    logic       ev_done;
    logic [1:0] ev;
    logic [1:0] clr;
    logic       lamp_prev_reg;
    // Entry marker; the ms count has already reached 2 s when the phase changes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lamp_prev_reg <= 1'b0;
        end else begin
            lamp_prev_reg <= phase_reg == self_test_pkg::ST_LAMP;
        end
    end
    // Fault event on entry to phase two
    assign hardware_fault_event = in_eval && lamp_prev_reg && hw_fail;
    assign ev_done = phase_reg == self_test_pkg::ST_RELAY && !active;
    assign ev      = {ev_done, hardware_fault_event};
    assign clr     = (do_write && awaddr_reg == `OFS_IRQ_CLEAR) ? wdata_reg[1:0] : 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= 2'h0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~clr) | ev;
        end
    end
    assign irq = |(irq_status_reg & irq_enable_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
                `OFS_CTRL:       s_axi_rdata <= {27'h0, ctrl_reg};
                `OFS_STATUS:     s_axi_rdata <= {29'h0, phase_reg};
                `OFS_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_status_reg};
                `OFS_IRQ_ENABLE: s_axi_rdata <= {30'h0, irq_enable_reg};
                `OFS_IRQ_CLEAR:  s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_lamp_on: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_reg == self_test_pkg::ST_LAMP |=> lamp_control && indicators_all_on)
        else $error("lamp test outputs not on");
    a_contactor_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_reg == self_test_pkg::ST_LAMP |=> contactor_out == $past(contactor_request))
        else $error("contactor changed in lamp test");
    a_fault_event: assert property (@(posedge aclk) disable iff (!aresetn)
        (phase_reg == self_test_pkg::ST_LAMP) ##1 (in_eval && hw_fail) |-> hardware_fault_event)
        else $error("fault event missed on phase two entry");
    a_event_late: assert property (@(posedge aclk) disable iff (!aresetn)
        hardware_fault_event |-> ms_reg >= 16'(`PHASE1_END_MS))
        else $error("fault event before two seconds");
    a_no_early_red: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_reg == self_test_pkg::ST_LAMP |=> device_led == self_test_pkg::LED_ORANGE)
        else $error("device led not orange in phase one");
    a_relay_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        in_eval && active && ms_reg >= 16'(`PHASE2_END_MS) |=> phase_reg == self_test_pkg::ST_RELAY)
        else $error("relay phase not entered");
    a_trip_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !trip_allowed |=> contactor_out == $past(contactor_request))
        else $error("contactor shut without permission");
    a_release_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_reg != self_test_pkg::ST_IDLE && !active |=> phase_reg == self_test_pkg::ST_IDLE)
        else $error("phase kept after release");
    a_fb_start: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_reg == self_test_pkg::ST_IDLE && start_pulse |=> phase_reg == self_test_pkg::ST_LAMP)
        else $error("fieldbus start ignored");
    a_gf_off_fail: assert property (@(posedge aclk) disable iff (!aresetn)
        in_eval && hw_fail |=> !general_fault_indicator)
        else $error("fault indicator shown on failure");
endmodule : timed_system_self_test
`default_nettype wire

// [timed_system_self_test_tb.sv]
// Self-checking bench for the timed system self-test block
`timescale 1ns/1ps
`default_nettype none
`include "self_test_consts.svh"
module timed_system_self_test_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, press = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, hold_cycles = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        hw_test_fail = 1'b0, contactor_request = 1'b0;
    logic [2:0]  main_current = 3'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, device_led;
    logic [31:0] s_axi_rdata;
    logic        test_button, contactor_out, lamp_control, indicators_all_on, irq;
    logic        general_fault_indicator, hardware_fault_event;
    int          errors = 0, comparisons = 0, cyc = 0, t0 = 0, hw_events = 0;

    // Tick shortened so a 5 s test fits in 20000 cycles
    timed_system_self_test #(.TICK_CYCLES(4)) DUT (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .test_button, .hw_test_fail, .main_current,
        .contactor_request, .contactor_out, .lamp_control, .indicators_all_on,
        .general_fault_indicator, .device_led, .hardware_fault_event, .irq
    );
    operator_panel panel (.aclk, .press, .hold_cycles, .test_button);

    initial begin
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (hardware_fault_event === 1'b1) hw_events <= hw_events + 1;
    end

    // ****************
    // Bus and checks
    // ****************
    task automatic complete_run();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic guard(inout int n);
        n++;
        if (n > 1000) begin
            errors++;
            complete_run();
        end
    endtask : guard
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid !== 1'b1) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            guard(n);
        end
        chk({30'h0, s_axi_bresp}, 32'h0);
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            guard(n);
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        chk(d, exp);
    endtask : rchk
    task automatic chk_irq(input logic e);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask : chk_irq
    task automatic at(input int c);
        while (cyc < t0 + c) @(posedge aclk);
        #1;
    endtask : at
    task automatic hold(input int n);
        @(posedge aclk);
        hold_cycles <= 32'(n);
        press <= 1'b1;
        t0 = cyc;
        @(posedge aclk);
        press <= 1'b0;
    endtask : hold
    task automatic toggles(input int n, output int t);
        logic p;
        t = 0;
        p = general_fault_indicator;
        repeat (n) begin
            @(posedge aclk);
            #1;
            if (general_fault_indicator !== p) t++;
            p = general_fault_indicator;
        end
    endtask : toggles

    // ****************
    // Scenarios
    // ****************
    initial begin
        int          t;
        logic [31:0] d;
        logic [1:0]  r;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`OFS_CTRL, 32'h0);
        rchk(`OFS_STATUS, 32'h0);
        rchk(`OFS_IRQ_ENABLE, 32'h0);
        axi_read(12'h100, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, 32'h2);
        // Button hold, pass, no current, trip with routed local control
        axi_write(`OFS_IRQ_ENABLE, 32'h3);
        axi_write(`OFS_CTRL, 32'he);
        contactor_request <= 1'b1;
        hold(22000);
        at(4000);
        chk({28'h0, lamp_control, indicators_all_on, general_fault_indicator, contactor_out},
            32'hf);
        chk(32'(device_led), 32'(self_test_pkg::LED_ORANGE));
        rchk(`OFS_STATUS, 32'h1);
        at(10000);
        toggles(4000, t);
        chk(32'(t >= 1 && t <= 3), 32'h1);
        chk({31'h0, contactor_out}, 32'h1);
        chk(32'(device_led), 32'(self_test_pkg::LED_GREEN));
        rchk(`OFS_STATUS, 32'h2);
        at(21000);
        chk({31'h0, contactor_out}, 32'h0);
        rchk(`OFS_STATUS, 32'h3);
        at(22500);
        rchk(`OFS_STATUS, 32'h0);
        rchk(`OFS_IRQ_STATUS, 32'h2);
        chk_irq(1'b1);
        axi_write(`OFS_IRQ_CLEAR, 32'h3);
        chk_irq(1'b0);
        // Fieldbus start, hardware failure, full current, interrupt masked
        @(posedge aclk);
        hw_test_fail <= 1'b1;
        main_current <= 3'h7;
        axi_write(`OFS_IRQ_ENABLE, 32'h0);
        axi_write(`OFS_CTRL, 32'hd);
        t0 = cyc;
        rchk(`OFS_CTRL, 32'hc);
        at(4000);
        chk(32'(hw_events), 32'h0);
        chk(32'(device_led), 32'(self_test_pkg::LED_ORANGE));
        chk({31'h0, contactor_out}, 32'h1);
        rchk(`OFS_IRQ_STATUS, 32'h0);
        rchk(`OFS_STATUS, 32'h1);
        at(12000);
        chk(32'(hw_events), 32'h1);
        chk(32'(device_led), 32'(self_test_pkg::LED_RED));
        chk({31'h0, contactor_out}, 32'h0);
        rchk(`OFS_IRQ_STATUS, 32'h1);
        chk_irq(1'b0);
        axi_write(`OFS_IRQ_ENABLE, 32'h1);
        chk_irq(1'b1);
        axi_write(`OFS_IRQ_CLEAR, 32'h1);
        chk_irq(1'b0);
        at(21000);
        rchk(`OFS_STATUS, 32'h0);
        rchk(`OFS_IRQ_STATUS, 32'h2);
        // Single-phase current, trip asked but button not routed
        hw_test_fail <= 1'b0;
        main_current <= 3'h1;
        axi_write(`OFS_CTRL, 32'h12);
        hold(22000);
        at(10000);
        toggles(4000, t);
        chk(32'(t >= 8 && t <= 12), 32'h1);
        at(21000);
        chk({31'h0, contactor_out}, 32'h1);
        rchk(`OFS_STATUS, 32'h3);
        // Three-phase load: two live phases stay dark, all three flicker
        at(22500);
        rchk(`OFS_STATUS, 32'h0);
        main_current <= 3'h3;
        axi_write(`OFS_CTRL, 32'h0);
        hold(10000);
        at(8500);
        toggles(400, t);
        chk({31'h0, general_fault_indicator}, 32'h0);
        chk(32'(t), 32'h0);
        rchk(`OFS_STATUS, 32'h2);
        main_current <= 3'h7;
        at(9000);
        toggles(800, t);
        chk(32'(t >= 1 && t <= 3), 32'h1);
        complete_run();
    end
endmodule : timed_system_self_test_tb
`default_nettype wire
